// [hw/tpms_pkg.sv]
// shared types and constants of the two-phase mode sequencer
package tpms_pkg;
   // register map (byte addresses)
   localparam logic [7:0] TPMS_CTRL_OFS = 8'h00;
   localparam logic [7:0] TPMS_STAT_OFS = 8'h04;
   localparam logic [31:0] TPMS_CTRL_RST = 32'h0000_0000;
   // ctrl fields
   localparam int TPMS_CTRL_BOOT_REL_BIT = 0;
   // status fields
   localparam int TPMS_STAT_STATE_LSB = 0;
   localparam int TPMS_STAT_SKIP_BIT = 4;
   localparam int TPMS_STAT_PH2_BIT = 5;
   localparam int TPMS_STAT_SLEW_LSB = 6;
   localparam int TPMS_STAT_BLANK_BIT = 8;
   localparam int TPMS_STAT_TEST_BIT = 9;
   localparam int TPMS_STAT_STRAP_BIT = 10;
   localparam int TPMS_STAT_CODE_LSB = 16;
   // slew scaling codes
   localparam logic [1:0] TPMS_SLEW_NORMAL = 2'h0;
   localparam logic [1:0] TPMS_SLEW_QUARTER = 2'h1;
   localparam logic [1:0] TPMS_SLEW_EIGHTH = 2'h2;
   localparam int TPMS_CODE_W = 7;
   localparam int TPMS_PHASES = 2;

   typedef enum logic [2:0] {
      ST_OFF, ST_STARTUP, ST_BOOT, ST_TO_VID, ST_RUN, ST_SOFT_OFF
   } tpms_state_e;

   typedef struct packed {
      logic shutdown_n;
      logic test_band;
      logic deep_sleep_select;
      logic power_state_indicator;
      logic deep_stop_n;
      logic phase2_sense_pos_at_vcc;
      logic [TPMS_CODE_W-1:0] voltage_code_inputs;
      logic in_regulation;
      logic ovp_detect;
      logic slew_settled;
      logic slew_down;
      logic transition_blank;
      logic [TPMS_PHASES-1:0] zero_cross;
      logic [TPMS_PHASES-1:0] pwm_high_req;
      logic [TPMS_PHASES-1:0] pwm_low_req;
   } tpms_pin_s;

   typedef struct packed {
      logic [TPMS_PHASES-1:0] high_drive;
      logic [TPMS_PHASES-1:0] low_drive;
      logic [TPMS_PHASES-1:0] boost_charge;
   } tpms_gate_s;

   typedef struct packed {
      logic skip_mode;
      logic phase2_enable;
      logic [1:0] slew_sel;
      logic [TPMS_CODE_W-1:0] target_code;
      logic pg_upper_blank;
      logic ovp_fixed_sel;
      logic prot_disable;
      logic fault_clear;
      logic overlap_disable;
      logic soar_disable;
   } tpms_ctl_s;
endpackage : tpms_pkg

// [hw/tpms_sequencer.sv]
// mode decoder, start/stop sequencer and gate-drive forcing of the core controller
//
// Contract
// - phase-two sense at supply disables phase two
// - high-side drives low in shutdown
// - low-side drives low in shutdown
// - overvoltage forces low-side high, beats negative limit
// - skip mode: zero crossing forces low-side low
// - boost switch on only while low-side high
// - target follows seven-line code; host drives lines
// - shutdown input low means shutdown, high runs
// - startup ramps to boot at eighth rate
// - soft shutdown ramps down at eighth rate
// - test band disables protection, overlap, boost switches
// - deep sleep high: immediate single-phase skip
// - leave skip only when select low and regulated
// - skip downward transition blanks upper good threshold
// - during blanking use fixed overvoltage threshold
// - select and indicator decode to mode table
// - startup two-phase skip, soft-off two-phase PWM
// - boot hold skip, boot-to-target two-phase PWM
// - strap-disabled phase two never runs
// - deep stop and select high: quarter slew
// - deep stop never alters mode or phases
// - select low: indicator picks one or two phases
`timescale 1ns/1ps
`default_nettype none
module tpms_sequencer
   import tpms_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire tpms_pin_s pins,
   output tpms_gate_s gate,
   output tpms_ctl_s ctl
);

////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   tpms_pin_s sync1_reg;
   tpms_pin_s pin_reg;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1_reg <= '0;
         pin_reg <= '0;
      end else begin
         sync1_reg <= pins;
         pin_reg <= sync1_reg;
      end
   end

////////////////////////////////////////////////////////////////////////////
   // ahb-lite slave
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] ctrl_reg;
   logic [31:0] stat_word;
   logic [31:0] ctrl_view;
   logic addr_phase;
   logic hreadyout_reg;
   logic [31:0] hrdata_reg;
   logic hresp_reg;
   tpms_state_e state_reg;
   tpms_state_e state_next;
   logic strap_off_reg;
   tpms_ctl_s ctl_reg;
   tpms_gate_s gate_reg;

   assign addr_phase = hsel && htrans[1] && hready;
   assign ctrl_view = (wr_pend_reg && wr_addr_reg == TPMS_CTRL_OFS) ?
                      hwdata : ctrl_reg;

   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[TPMS_STAT_STATE_LSB +: 3] = state_reg;
      stat_word[TPMS_STAT_SKIP_BIT] = ctl_reg.skip_mode;
      stat_word[TPMS_STAT_PH2_BIT] = ctl_reg.phase2_enable;
      stat_word[TPMS_STAT_SLEW_LSB +: 2] = ctl_reg.slew_sel;
      stat_word[TPMS_STAT_BLANK_BIT] = ctl_reg.pg_upper_blank;
      stat_word[TPMS_STAT_TEST_BIT] = ctl_reg.prot_disable;
      stat_word[TPMS_STAT_STRAP_BIT] = strap_off_reg;
      stat_word[TPMS_STAT_CODE_LSB +: TPMS_CODE_W] = ctl_reg.target_code;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= addr_phase && hwrite;
         wr_addr_reg <= haddr[7:0];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg <= TPMS_CTRL_RST;
      end else if (wr_pend_reg && wr_addr_reg == TPMS_CTRL_OFS) begin
         ctrl_reg <= {31'h0000_0000, hwdata[TPMS_CTRL_BOOT_REL_BIT]};
      end
   end

   // read data captured in the address phase, shown in the data phase
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         if (haddr[7:0] == TPMS_CTRL_OFS) begin
            hrdata_reg <= {31'h0000_0000, ctrl_view[TPMS_CTRL_BOOT_REL_BIT]};
         end else if (haddr[7:0] == TPMS_STAT_OFS) begin
            hrdata_reg <= stat_word;
         end else begin
            hrdata_reg <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end else begin
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end
   end

   assign hreadyout = hreadyout_reg;
   assign hrdata = hrdata_reg;
   assign hresp = hresp_reg;

////////////////////////////////////////////////////////////////////////////
   // start/stop sequencer
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_OFF: if (pin_reg.shutdown_n) state_next = ST_STARTUP;
         ST_STARTUP: if (pin_reg.slew_settled) state_next = ST_BOOT;
         ST_BOOT: if (ctrl_reg[TPMS_CTRL_BOOT_REL_BIT]) state_next = ST_TO_VID;
         ST_TO_VID: if (pin_reg.slew_settled) state_next = ST_RUN;
         ST_RUN: state_next = ST_RUN;
         ST_SOFT_OFF: if (pin_reg.slew_settled) state_next = ST_OFF;
      endcase
      if (!pin_reg.shutdown_n && state_reg != ST_OFF &&
          state_reg != ST_SOFT_OFF) begin
         state_next = ST_SOFT_OFF;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   // strap is only taken while idle so it cannot change mid-operation
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         strap_off_reg <= 1'b0;
      end else if (state_reg == ST_OFF) begin
         strap_off_reg <= pin_reg.phase2_sense_pos_at_vcc;
      end
   end

////////////////////////////////////////////////////////////////////////////
   // mode decode, slew scaling, blanking, test band
   logic skip_next;
   logic two_next;
   logic blank_next;
   logic [1:0] slew_next;
   logic test_on;

   assign test_on = pin_reg.test_band;

   always_comb begin
      skip_next = 1'b0;
      two_next = 1'b0;
      unique case (state_reg)
         ST_OFF: {skip_next, two_next} = 2'b00;
         ST_STARTUP, ST_BOOT: {skip_next, two_next} = 2'b11;
         ST_TO_VID, ST_SOFT_OFF:
            {skip_next, two_next} = 2'b01;
         ST_RUN: begin
            // deep stop deliberately absent here
            if (pin_reg.deep_sleep_select) begin
               skip_next = 1'b1;
               two_next = 1'b0;
            end else if (ctl_reg.skip_mode && !pin_reg.in_regulation) begin
               skip_next = 1'b1;
               two_next = 1'b0;
            end else begin
               skip_next = 1'b0;
               two_next = pin_reg.power_state_indicator;
            end
         end
      endcase
   end

   always_comb begin
      if (state_reg == ST_STARTUP || state_reg == ST_SOFT_OFF) begin
         slew_next = TPMS_SLEW_EIGHTH;
      end else if (pin_reg.deep_sleep_select && pin_reg.deep_stop_n) begin
         slew_next = TPMS_SLEW_QUARTER;
      end else begin
         slew_next = TPMS_SLEW_NORMAL;
      end
   end

   // set wins over clear
   always_comb begin
      blank_next = ctl_reg.pg_upper_blank;
      if (!pin_reg.transition_blank && pin_reg.in_regulation) begin
         blank_next = 1'b0;
      end
      if (ctl_reg.skip_mode && pin_reg.slew_down) begin
         blank_next = 1'b1;
      end
      if (state_reg == ST_OFF) begin
         blank_next = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctl_reg <= '0;
      end else begin
         ctl_reg.skip_mode <= skip_next;
         ctl_reg.phase2_enable <= two_next && !strap_off_reg;
         ctl_reg.slew_sel <= slew_next;
         ctl_reg.target_code <= pin_reg.voltage_code_inputs;
         ctl_reg.pg_upper_blank <= blank_next;
         ctl_reg.ovp_fixed_sel <= blank_next;
         ctl_reg.prot_disable <= test_on;
         ctl_reg.fault_clear <= test_on;
         ctl_reg.overlap_disable <= test_on;
         ctl_reg.soar_disable <= test_on;
      end
   end

   assign ctl = ctl_reg;

////////////////////////////////////////////////////////////////////////////
   // per-phase gate drive forcing
   logic [TPMS_PHASES-1:0] ph_on;
   logic [TPMS_PHASES-1:0] zc_seen_reg;
   logic [TPMS_PHASES-1:0] lo_next;
   logic running;

   assign running = state_reg != ST_OFF;
   assign ph_on[0] = running;
   assign ph_on[1] = running && ctl_reg.phase2_enable;

   generate
      for (genvar g = 0; g < TPMS_PHASES; g++) begin : g_phase
         // zero crossing holds the low side off until the next on-time
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               zc_seen_reg[g] <= 1'b0;
            end else if (!ctl_reg.skip_mode) begin
               zc_seen_reg[g] <= 1'b0;
            end else if (pin_reg.zero_cross[g]) begin
               zc_seen_reg[g] <= 1'b1;
            end else if (pin_reg.pwm_high_req[g]) begin
               zc_seen_reg[g] <= 1'b0;
            end
         end

         always_comb begin
            if (!ph_on[g]) begin
               lo_next[g] = 1'b0;
            end else if (pin_reg.ovp_detect && !test_on) begin
               lo_next[g] = 1'b1;
            end else if (ctl_reg.skip_mode &&
                         (zc_seen_reg[g] || pin_reg.zero_cross[g])) begin
               lo_next[g] = 1'b0;
            end else begin
               lo_next[g] = pin_reg.pwm_low_req[g];
            end
         end

         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               gate_reg.high_drive[g] <= 1'b0;
               gate_reg.low_drive[g] <= 1'b0;
               gate_reg.boost_charge[g] <= 1'b0;
            end else begin
               gate_reg.high_drive[g] <= ph_on[g] &&
                  pin_reg.pwm_high_req[g] && !lo_next[g];
               gate_reg.low_drive[g] <= lo_next[g];
               gate_reg.boost_charge[g] <= lo_next[g] && !test_on;
            end
         end
      end
   endgenerate

   assign gate = gate_reg;

////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   property p_high_off;
      state_reg == ST_OFF |=> gate.high_drive == 2'b00;
   endproperty
   a_high_off: assert property (p_high_off)
      else $error("high-side drive active in shutdown");

   property p_low_off;
      state_reg == ST_OFF |=> gate.low_drive == 2'b00;
   endproperty
   a_low_off: assert property (p_low_off)
      else $error("low-side drive active in shutdown");

   property p_ovp_low;
      pin_reg.ovp_detect && !test_on && running |=> gate.low_drive[0];
   endproperty
   a_ovp_low: assert property (p_ovp_low)
      else $error("overvoltage did not force low side high");

   property p_boost;
      gate.boost_charge != 2'b00 |-> (gate.low_drive & gate.boost_charge)
         == gate.boost_charge && !ctl.prot_disable;
   endproperty
   a_boost: assert property (p_boost)
      else $error("boost switch on without low-side drive");

   property p_startup_mode;
      state_reg == ST_STARTUP |=> ctl.skip_mode &&
         ctl.phase2_enable == !strap_off_reg && ctl.slew_sel == 2'h2;
   endproperty
   a_startup_mode: assert property (p_startup_mode)
      else $error("startup not two-phase skip at eighth slew");

   property p_softoff_slew;
      state_reg == ST_SOFT_OFF |=> !ctl.skip_mode &&
         ctl.slew_sel == 2'h2;
   endproperty
   a_softoff_slew: assert property (p_softoff_slew)
      else $error("soft shutdown not forced PWM at eighth slew");

   property p_dss_skip;
      state_reg == ST_RUN && pin_reg.deep_sleep_select |=>
         ctl.skip_mode && !ctl.phase2_enable;
   endproperty
   a_dss_skip: assert property (p_dss_skip)
      else $error("deep sleep select did not give single-phase skip");

   property p_skip_hold;
      state_reg == ST_RUN && ctl.skip_mode && !pin_reg.in_regulation |=>
         ctl.skip_mode;
   endproperty
   a_skip_hold: assert property (p_skip_hold)
      else $error("left skip mode while out of regulation");

   property p_quarter;
      state_reg == ST_RUN && pin_reg.deep_sleep_select &&
         pin_reg.deep_stop_n |=> ctl.slew_sel == 2'h1;
   endproperty
   a_quarter: assert property (p_quarter)
      else $error("quarter slew not selected");

   property p_strap;
      strap_off_reg |=> !ctl.phase2_enable && !gate.low_drive[1];
   endproperty
   a_strap: assert property (p_strap)
      else $error("strapped-off phase two active");

   property p_ovp_sel;
      ctl_reg.skip_mode && pin_reg.slew_down && running |=> ctl.ovp_fixed_sel;
   endproperty
   a_ovp_sel: assert property (p_ovp_sel)
      else $error("fixed overvoltage threshold not selected on skip downslew");

   c_boot: cover property (state_reg == ST_BOOT ##1 state_reg == ST_TO_VID);
   c_run_skip: cover property (state_reg == ST_RUN && ctl.skip_mode);
   c_off: cover property (state_reg == ST_SOFT_OFF ##1 state_reg == ST_OFF);
   c_blank: cover property (ctl.pg_upper_blank);

endmodule : tpms_sequencer
`default_nettype wire

// [bench/tpms_far_side.sv]
// far-side model: slew controller and power stage behind the gate drives
`timescale 1ns/1ps
`default_nettype none
module tpms_far_side
   import tpms_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire tpms_gate_s gate,
   input wire logic ramp_go,
   input wire logic [7:0] ramp_len,
   output logic slew_settled,
   output logic [TPMS_PHASES-1:0] zero_cross
);
   logic [7:0] ramp_cnt_reg;
   logic [TPMS_PHASES-1:0][2:0] dis_cnt_reg;
   ////////////////////////////////////////////////////////////////////////
   // settled drops for the ramp_go cycle plus ramp_len cycles, so a short or long ramp can be asked
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ramp_cnt_reg <= 8'h00;
      end else if (ramp_go) begin
         ramp_cnt_reg <= ramp_len;
      end else if (ramp_cnt_reg != 8'h00) begin
         ramp_cnt_reg <= ramp_cnt_reg - 8'h01;
      end
   end
   assign slew_settled = (ramp_cnt_reg == 8'h00) && !ramp_go;
   ////////////////////////////////////////////////////////////////////////
   // inductor current decays to zero four cycles after the low side turns on
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dis_cnt_reg <= '0;
      end else begin
         for (int i = 0; i < TPMS_PHASES; i++) begin
            if (!gate.low_drive[i]) begin
               dis_cnt_reg[i] <= 3'h0;
            end else if (dis_cnt_reg[i] != 3'h4) begin
               dis_cnt_reg[i] <= dis_cnt_reg[i] + 3'h1;
            end
         end
      end
   end
   always_comb begin
      for (int i = 0; i < TPMS_PHASES; i++) begin
         zero_cross[i] = (dis_cnt_reg[i] == 3'h4);
      end
   end
endmodule : tpms_far_side
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for the two-phase mode sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench
   import tpms_pkg::*;
();
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic [31:0] hrdata;
   logic hresp;
   tpms_pin_s pd;
   tpms_pin_s pins_w;
   tpms_gate_s gate;
   tpms_ctl_s ctl;
   logic ramp_go = 1'b0;
   logic [7:0] ramp_len = 8'h00;
   logic settled;
   logic [TPMS_PHASES-1:0] zc;
   logic [31:0] d;
   int mismatches = 0;
   int total_checks = 0;

   always #5 clk = ~clk;
   always_comb begin
      pins_w = pd;
      pins_w.slew_settled = settled;
      pins_w.zero_cross = zc;
   end

   tpms_sequencer dut(.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .pins(pins_w), .gate(gate), .ctl(ctl));
   tpms_far_side far_side(.clk(clk), .nrst(nrst), .gate(gate),
      .ramp_go(ramp_go), .ramp_len(ramp_len), .slew_settled(settled),
      .zero_cross(zc));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk_word(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_word
   task automatic chk_bit(input string nm, input logic e, input logic g);
      chk_word(nm, {31'h0, e}, {31'h0, g});
   endtask : chk_bit
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////
   // one single word transfer; waits on hready in both phases
   task automatic ahb_xfer(input logic [7:0] a, input logic w,
                           input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk_bit("hresp", 1'b0, hresp);
   endtask : ahb_xfer
   task automatic ahb_wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] dummy;
      ahb_xfer(a, 1'b1, wd, dummy);
   endtask : ahb_wr
   task automatic st(input logic [2:0] e);
      ahb_xfer(TPMS_STAT_OFS, 1'b0, 32'h0, d);
      chk_word("state", {29'h0, e}, {29'h0, d[2:0]});
   endtask : st
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_cyc
   task automatic ramp(input logic [7:0] len);
      @(posedge clk);
      ramp_len <= len;
      ramp_go <= 1'b1;
      @(posedge clk);
      ramp_go <= 1'b0;
   endtask : ramp
   task automatic mode(input logic s, input logic i, input logic n);
      @(posedge clk);
      pd.deep_sleep_select <= s;
      pd.power_state_indicator <= i;
      pd.deep_stop_n <= n;
   endtask : mode
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      print_verdict();
   end

   initial begin
      pd = '0;
      pd.voltage_code_inputs = 7'h2A;
      pd.pwm_high_req = 2'b11;
      pd.pwm_low_req = 2'b11;
      pd.in_regulation = 1'b1;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      wait_cyc(8);
      chk_word("gate_off", 32'h0, {26'h0, gate});
      ahb_xfer(TPMS_CTRL_OFS, 1'b0, 32'h0, d);
      chk_word("ctrl_rst", TPMS_CTRL_RST, d);
      ahb_xfer(8'h40, 1'b0, 32'h0, d);
      chk_word("unmapped", 32'h0, d);
      ahb_wr(TPMS_STAT_OFS, 32'hFFFF_FFFF);
      st(3'h0);
      $display("test reset done");
      ramp(8'd40);
      pd.shutdown_n <= 1'b1;
      wait_cyc(6);
      st(3'h1);
      chk_bit("su_skip", 1'b1, ctl.skip_mode);
      chk_bit("su_ph2", 1'b1, ctl.phase2_enable);
      chk_word("su_slew", 32'(TPMS_SLEW_EIGHTH), 32'(ctl.slew_sel));
      wait_cyc(50);
      st(3'h2);
      chk_bit("boot_skip", 1'b1, ctl.skip_mode);
      ramp(8'd30);
      ahb_wr(TPMS_CTRL_OFS, 32'hFFFF_FFFF);
      ahb_xfer(TPMS_CTRL_OFS, 1'b0, 32'h0, d);
      chk_word("ctrl_wr", 32'h1, d);
      wait_cyc(4);
      st(3'h3);
      chk_bit("tv_skip", 1'b0, ctl.skip_mode);
      chk_bit("tv_ph2", 1'b1, ctl.phase2_enable);
      wait_cyc(40);
      st(3'h4);
      chk_word("code", 32'h2A, 32'(ctl.target_code));
      @(posedge clk);
      pd.voltage_code_inputs <= 7'h55;
      wait_cyc(6);
      chk_word("code2", 32'h55, 32'(ctl.target_code));
      $display("test startup done");
      for (int k = 0; k < 8; k++) begin
         mode(k[2], k[1], k[0]);
         wait_cyc(6);
         chk_bit("skip", k[2], ctl.skip_mode);
         chk_bit("ph2", !k[2] && k[1], ctl.phase2_enable);
         chk_word("slew", 32'((k[2] && k[0]) ? TPMS_SLEW_QUARTER :
            TPMS_SLEW_NORMAL), 32'(ctl.slew_sel));
      end
      mode(1'b0, 1'b1, 1'b1);
      pd.in_regulation <= 1'b0;
      wait_cyc(8);
      chk_bit("skip_hold", 1'b1, ctl.skip_mode);
      @(posedge clk);
      pd.in_regulation <= 1'b1;
      wait_cyc(6);
      chk_bit("skip_left", 1'b0, ctl.skip_mode);
      $display("test modes done");
      mode(1'b1, 1'b1, 1'b1);
      pd.slew_down <= 1'b1;
      pd.transition_blank <= 1'b1;
      pd.in_regulation <= 1'b0;
      wait_cyc(6);
      chk_bit("blank_on", 1'b1, ctl.pg_upper_blank);
      chk_bit("ovp_fix", 1'b1, ctl.ovp_fixed_sel);
      @(posedge clk);
      pd.slew_down <= 1'b0;
      pd.in_regulation <= 1'b1;
      wait_cyc(6);
      chk_bit("blank_hold", 1'b1, ctl.pg_upper_blank);
      @(posedge clk);
      pd.transition_blank <= 1'b0;
      wait_cyc(6);
      chk_bit("blank_off", 1'b0, ctl.pg_upper_blank);
      chk_bit("ovp_track", 1'b0, ctl.ovp_fixed_sel);
      $display("test blanking done");
      mode(1'b0, 1'b1, 1'b1);
      pd.pwm_high_req <= 2'b01;
      pd.pwm_low_req <= 2'b10;
      wait_cyc(10);
      chk_word("high", 32'h1, 32'(gate.high_drive));
      chk_word("low", 32'h2, 32'(gate.low_drive));
      chk_word("boost", 32'h2, 32'(gate.boost_charge));
      @(posedge clk);
      pd.ovp_detect <= 1'b1;
      wait_cyc(6);
      chk_word("ovp_low", 32'h3, 32'(gate.low_drive));
      chk_word("ovp_boost", 32'h3, 32'(gate.boost_charge));
      @(posedge clk);
      pd.ovp_detect <= 1'b0;
      mode(1'b1, 1'b0, 1'b1);
      pd.pwm_high_req <= 2'b00;
      pd.pwm_low_req <= 2'b01;
      wait_cyc(16);
      chk_word("zc_low", 32'h0, 32'(gate.low_drive));
      chk_word("zc_boost", 32'h0, 32'(gate.boost_charge));
      $display("test gates done");
      mode(1'b0, 1'b1, 1'b1);
      pd.pwm_low_req <= 2'b11;
      pd.test_band <= 1'b1;
      wait_cyc(8);
      chk_word("tb_ctl", 32'hF, 32'({ctl.prot_disable, ctl.fault_clear,
         ctl.overlap_disable, ctl.soar_disable}));
      chk_word("tb_boost", 32'h0, 32'(gate.boost_charge));
      @(posedge clk);
      pd.test_band <= 1'b0;
      wait_cyc(6);
      chk_word("tb_boost2", 32'h3, 32'(gate.boost_charge));
      $display("test band done");
      ramp(8'd40);
      pd.shutdown_n <= 1'b0;
      pd.pwm_high_req <= 2'b11;
      wait_cyc(6);
      st(3'h5);
      chk_bit("so_skip", 1'b0, ctl.skip_mode);
      chk_bit("so_ph2", 1'b1, ctl.phase2_enable);
      chk_word("so_slew", 32'(TPMS_SLEW_EIGHTH), 32'(ctl.slew_sel));
      wait_cyc(50);
      st(3'h0);
      chk_word("off_high", 32'h0, 32'(gate.high_drive));
      chk_word("off_low", 32'h0, 32'(gate.low_drive));
      @(posedge clk);
      pd.phase2_sense_pos_at_vcc <= 1'b1;
      wait_cyc(6);
      ramp(8'd40);
      pd.shutdown_n <= 1'b1;
      wait_cyc(6);
      st(3'h1);
      chk_bit("strap_ph2", 1'b0, ctl.phase2_enable);
      chk_word("strap_low", 32'h0, 32'(gate.low_drive[1]));
      $display("test shutdown and strap done");
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
